// File: src/ctb_pkg.sv
// constants and carriers for the charge timer / boost config register pair
// assumes one system clock and a serial-port engine that issues byte accesses
package ctb_pkg;
	// register addresses on the serial control port
	localparam logic [7:0] CTB_ADDR_TMR = 8'h05;
	localparam logic [7:0] CTB_ADDR_BST = 8'h06;
	// reset values
	localparam logic [7:0] CTB_TMR_RST = 8'h9C;
	localparam logic [7:0] CTB_BST_RST = 8'h73;
	localparam logic [7:0] CTB_UNMAPPED = 8'h00;
	// field positions, charge_term_timer_ctrl
	localparam int CTB_TERM_BIT = 7;
	localparam int CTB_WD_LSB = 4;
	localparam int CTB_TIMER_EN_BIT = 3;
	localparam int CTB_FCT_LSB = 1;
	// field positions, boost_volt_thermal_ctrl
	localparam int CTB_BV_LSB = 4;
	localparam int CTB_HOT_LSB = 2;
	localparam int CTB_DIE_REGULATION_TEMP_SELECT_LSB = 0;
	// watchdog periods, seconds
	localparam logic [7:0] CTB_WD_OFF_S = 8'h00;
	localparam logic [7:0] CTB_WD_40_S = 8'h28;
	localparam logic [7:0] CTB_WD_80_S = 8'h50;
	localparam logic [7:0] CTB_WD_160_S = 8'hA0;
	// fast-charge limits, hours
	localparam logic [4:0] CTB_FCT_5_H = 5'h05;
	localparam logic [4:0] CTB_FCT_8_H = 5'h08;
	localparam logic [4:0] CTB_FCT_12_H = 5'h0C;
	localparam logic [4:0] CTB_FCT_20_H = 5'h14;
	// boost target, millivolts
	localparam logic [12:0] CTB_BV_BASE_MV = 13'h11C6;
	localparam logic [12:0] CTB_BV_STEP_MV = 13'h0040;
	// die regulation temperatures, degrees C
	localparam logic [6:0] CTB_DIE_REGULATION_TEMP_SELECT_60_C = 7'h3C;
	localparam logic [6:0] CTB_DIE_REGULATION_TEMP_SELECT_80_C = 7'h50;
	localparam logic [6:0] CTB_DIE_REGULATION_TEMP_SELECT_100_C = 7'h64;
	localparam logic [6:0] CTB_DIE_REGULATION_TEMP_SELECT_120_C = 7'h78;
	// hot threshold select codes and comparator lane indexes
	localparam logic [1:0] CTB_HOT_33 = 2'h0;
	localparam logic [1:0] CTB_HOT_36 = 2'h1;
	localparam logic [1:0] CTB_HOT_30 = 2'h2;
	localparam logic [1:0] CTB_HOT_OFF = 2'h3;

	// byte access from the serial-port engine
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} ctb_req_type;

	// decoded configuration toward charger, watchdog and boost logic
	typedef struct packed {
		logic term_en;
		logic wd_en;
		logic [7:0] wd_period_s;
		logic safety_timer_en;
		logic [4:0] fast_charge_time_limit;
		logic [12:0] otg_target_mv;
		logic [1:0] hot_select;
		logic boost_hot_protect_en;
		logic [6:0] die_regulation_temp_select;
	} ctb_cfg_type;
endpackage

// File: src/ctb_regs.sv
// charge-termination / timer and boost-voltage / thermal configuration registers
// assumes the serial-port engine hands over decoded byte accesses synchronous to clk
// Notes on behaviour
// - bit 7 enables termination, resets enabled
// - watchdog field: off, 40, 80, 160 s
// - safety timer enable; limit 5/8/12/20 h
// - boost target 4.55 V plus 64 mV steps
// - hot select 33/36/30 percent or off
// - select 11: boost runs, fault uses 33 percent
// - regulation temperature 60/80/100/120 C, default 120
// - boost/thermal register resets to 0x73
// - termination/timer register resets to 0x9C
module ctb_regs
	import ctb_pkg::*;
(
	// clock, reset, enable
	input wire logic clk,
	input wire logic nrst,
	input wire logic ce,
	// register access from the serial control port
	input wire ctb_req_type req,
	output logic [7:0] rdata,
	output logic rvalid,
	// thermistor hot comparators: [0] 33 %, [1] 36 %, [2] 30 % of internal_regulator_rail
	input wire logic [2:0] ntc_hot_cross,
	// decoded configuration and boost thermal results
	output ctb_cfg_type cfg,
	output logic boost_hot_stop,
	output logic thermistor_fault_flag
);

	// watchdog code to seconds
	function automatic logic [7:0] wd_decode(input logic [1:0] code);
		case (code)
			2'h0: wd_decode = CTB_WD_OFF_S;
			2'h1: wd_decode = CTB_WD_40_S;
			2'h2: wd_decode = CTB_WD_80_S;
			default: wd_decode = CTB_WD_160_S;
		endcase
	endfunction

	// fast-charge code to hours
	function automatic logic [4:0] fct_decode(input logic [1:0] code);
		case (code)
			2'h0: fct_decode = CTB_FCT_5_H;
			2'h1: fct_decode = CTB_FCT_8_H;
			2'h2: fct_decode = CTB_FCT_12_H;
			default: fct_decode = CTB_FCT_20_H;
		endcase
	endfunction

	// regulation code to degrees
	function automatic logic [6:0] die_regulation_temp_select_decode(input logic [1:0] code);
		case (code)
			2'h0: die_regulation_temp_select_decode = CTB_DIE_REGULATION_TEMP_SELECT_60_C;
			2'h1: die_regulation_temp_select_decode = CTB_DIE_REGULATION_TEMP_SELECT_80_C;
			2'h2: die_regulation_temp_select_decode = CTB_DIE_REGULATION_TEMP_SELECT_100_C;
			default: die_regulation_temp_select_decode = CTB_DIE_REGULATION_TEMP_SELECT_120_C;
		endcase
	endfunction

	// boost code to millivolts; the weights are binary so a multiply is exact
	function automatic logic [12:0] bv_decode(input logic [3:0] code);
		bv_decode = 13'(CTB_BV_BASE_MV + 13'(code) * CTB_BV_STEP_MV);
	endfunction

	// has the selected comparator tripped; select 11 reads the 33 % lane
	function automatic logic hot_crossed(input logic [1:0] sel, input logic [2:0] lanes);
		case (sel)
			CTB_HOT_36: hot_crossed = lanes[1];
			CTB_HOT_30: hot_crossed = lanes[2];
			default: hot_crossed = lanes[0];
		endcase
	endfunction

	logic [7:0] tmr_reg, tmr_next;
	logic [7:0] bst_reg, bst_next;
	logic [7:0] rdata_reg, rdata_next;
	logic rvalid_reg, rvalid_next;
	ctb_cfg_type cfg_reg, cfg_next;
	logic hot_stop_reg, hot_stop_next;
	logic thermistor_fault_flag_reg, thermistor_fault_flag_next;

	// register writes; whole bytes are kept, reserved bits included
	always_comb begin
		tmr_next = tmr_reg;
		bst_next = bst_reg;
		if (ce && req.wr && req.addr == CTB_ADDR_TMR) begin
			tmr_next = req.wdata;
		end
		if (ce && req.wr && req.addr == CTB_ADDR_BST) begin
			bst_next = req.wdata;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			tmr_reg <= CTB_TMR_RST;
			bst_reg <= CTB_BST_RST;
		end else begin
			tmr_reg <= tmr_next;
			bst_reg <= bst_next;
		end
	end

	// read port; unmapped addresses answer zero so the engine always gets a byte
	always_comb begin
		rdata_next = rdata_reg;
		rvalid_next = 1'b0;
		if (ce) begin
			rvalid_next = req.rd;
			if (req.rd) begin
				case (req.addr)
					CTB_ADDR_TMR: rdata_next = tmr_reg;
					CTB_ADDR_BST: rdata_next = bst_reg;
					default: rdata_next = CTB_UNMAPPED;
				endcase
			end
		end else begin
			rvalid_next = rvalid_reg;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rdata_reg <= CTB_UNMAPPED;
			rvalid_reg <= 1'b0;
		end else begin
			rdata_reg <= rdata_next;
			rvalid_reg <= rvalid_next;
		end
	end

	// decoded configuration, one cycle behind the stored bytes
	always_comb begin
		cfg_next = cfg_reg;
		if (ce) begin
			cfg_next.term_en = tmr_reg[CTB_TERM_BIT];
			cfg_next.wd_en = tmr_reg[CTB_WD_LSB +: 2] != 2'h0;
			cfg_next.wd_period_s = wd_decode(tmr_reg[CTB_WD_LSB +: 2]);
			cfg_next.safety_timer_en = tmr_reg[CTB_TIMER_EN_BIT];
			cfg_next.fast_charge_time_limit = fct_decode(tmr_reg[CTB_FCT_LSB +: 2]);
			cfg_next.otg_target_mv = bv_decode(bst_reg[CTB_BV_LSB +: 4]);
			cfg_next.hot_select = bst_reg[CTB_HOT_LSB +: 2];
			cfg_next.boost_hot_protect_en = bst_reg[CTB_HOT_LSB +: 2] != CTB_HOT_OFF;
			cfg_next.die_regulation_temp_select = die_regulation_temp_select_decode(bst_reg[CTB_DIE_REGULATION_TEMP_SELECT_LSB +: 2]);
		end
	end

	// reset decode matches the reset bytes so outputs are right from the first cycle
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cfg_reg <= '{term_en: 1'b1, wd_en: 1'b1, wd_period_s: CTB_WD_40_S, safety_timer_en: 1'b1,
				fast_charge_time_limit: CTB_FCT_12_H, otg_target_mv: 13'h1386, hot_select: CTB_HOT_33,
				boost_hot_protect_en: 1'b1, die_regulation_temp_select: CTB_DIE_REGULATION_TEMP_SELECT_120_C};
		end else begin
			cfg_reg <= cfg_next;
		end
	end

	// boost thermal: stop on the selected level, fault flag keeps watching 33 % when protection is off
	always_comb begin
		hot_stop_next = hot_stop_reg;
		thermistor_fault_flag_next = thermistor_fault_flag_reg;
		if (ce) begin
			hot_stop_next = (bst_reg[CTB_HOT_LSB +: 2] != CTB_HOT_OFF)
				&& hot_crossed(bst_reg[CTB_HOT_LSB +: 2], ntc_hot_cross);
			thermistor_fault_flag_next = hot_crossed(bst_reg[CTB_HOT_LSB +: 2], ntc_hot_cross);
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			hot_stop_reg <= 1'b0;
			thermistor_fault_flag_reg <= 1'b0;
		end else begin
			hot_stop_reg <= hot_stop_next;
			thermistor_fault_flag_reg <= thermistor_fault_flag_next;
		end
	end

	assign rdata = rdata_reg;
	assign rvalid = rvalid_reg;
	assign cfg = cfg_reg;
	assign boost_hot_stop = hot_stop_reg;
	assign thermistor_fault_flag = thermistor_fault_flag_reg;

	// marks the first clock after reset release, for the reset-value checks
	logic seen_reg;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			seen_reg <= 1'b0;
		end else begin
			seen_reg <= 1'b1;
		end
	end

	AST_TERM_EN: assert property (@(posedge clk) disable iff (!nrst)
		ce |=> cfg.term_en == $past(tmr_reg[7])) else $error("termination enable does not follow bit 7");
	AST_WD_PERIOD: assert property (@(posedge clk) disable iff (!nrst)
		ce && tmr_reg[5:4] == 2'h1 |=> cfg.wd_period_s == 8'h28 && cfg.wd_en)
		else $error("watchdog code 01 not decoded as 40 s");
	AST_FCT_LIMIT: assert property (@(posedge clk) disable iff (!nrst)
		ce |=> cfg.fast_charge_time_limit == fct_decode($past(tmr_reg[2:1]))
			&& cfg.safety_timer_en == $past(tmr_reg[3])) else $error("safety timer decode wrong");
	AST_BOOST_MV: assert property (@(posedge clk) disable iff (!nrst)
		ce && bst_reg[7:4] == 4'h7 |=> cfg.otg_target_mv == 13'h1386)
		else $error("boost code 0111 not 4998 mV");
	AST_HOT_STOP: assert property (@(posedge clk) disable iff (!nrst)
		ce && bst_reg[3:2] == 2'h2 && ntc_hot_cross[2] |=> boost_hot_stop)
		else $error("boost not stopped at 30 percent level");
	AST_HOT_OFF: assert property (@(posedge clk) disable iff (!nrst)
		ce && bst_reg[3:2] == 2'h3 |=> !boost_hot_stop
			&& thermistor_fault_flag == $past(ntc_hot_cross[0])) else $error("disabled protection misbehaves");
	AST_DIE_REGULATION_TEMP_SELECT: assert property (@(posedge clk) disable iff (!nrst)
		ce && bst_reg[1:0] == 2'h0 |=> cfg.die_regulation_temp_select == 7'h3C)
		else $error("regulation code 00 not 60 C");
	AST_BST_RESET: assert property (@(posedge clk) disable iff (!nrst)
		!seen_reg |-> bst_reg == 8'h73) else $error("boost register reset value wrong");
	AST_TMR_RESET: assert property (@(posedge clk) disable iff (!nrst)
		!seen_reg |-> tmr_reg == 8'h9C) else $error("timer register reset value wrong");
	AST_READBACK: assert property (@(posedge clk) disable iff (!nrst)
		ce && req.wr && req.addr == 8'h05 ##1 ce && req.rd && !req.wr && req.addr == 8'h05
			|=> rvalid && rdata == $past(req.wdata, 2)) else $error("written byte not read back");
endmodule

// File: tb/ctb_host.sv
// host model for the serial control port: issues single byte writes and reads
// assumes the register block samples req on rising clk with ce held high
module ctb_host
	import ctb_pkg::*;
(
	// clock
	input wire logic clk,
	// byte access toward the register block
	output ctb_req_type req,
	input wire logic [7:0] rdata,
	input wire logic rvalid
);
	timeunit 1ns;
	timeprecision 100ps;
	// idle request at time zero
	initial begin
		req = '0;
	end
	// released lines show the inverse of the last value, so stale data never looks valid
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge clk);
		req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
		@(posedge clk);
		#1;
	endtask
	// the answer is taken one cycle after the request edge, while rvalid stands
	task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
		@(posedge clk);
		req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(posedge clk);
		req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hFF};
		#1;
		ok = rvalid;
		d = rdata;
	endtask
	// write then read the same address on the very next edge, no idle cycle between
	task automatic wr_rd(input logic [7:0] a, input logic [7:0] wd, output logic [7:0] d, output logic ok);
		@(posedge clk);
		req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: wd};
		@(posedge clk);
		req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(posedge clk);
		req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hFF};
		#1;
		ok = rvalid;
		d = rdata;
	endtask
endmodule

// File: tb/ctb_regs_bench.sv
// self-checking bench for the charge timer / boost config register pair
// assumes ctb_host drives the access port; ce is high except in the enable test
module ctb_regs_bench
	import ctb_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk, nrst, ce, rvalid, ok, boost_hot_stop, thermistor_fault_flag;
	logic [2:0] ntc_hot_cross;
	logic [7:0] rdata, d;
	ctb_req_type req;
	ctb_cfg_type cfg;
	int fails, n_compared;
	logic [7:0] wd_tab[4] = '{8'h00, 8'h28, 8'h50, 8'hA0};
	logic [4:0] fct_tab[4] = '{5'h05, 5'h08, 5'h0C, 5'h14};
	logic [6:0] die_regulation_temp_select_tab[4] = '{7'h3C, 7'h50, 7'h64, 7'h78};
	ctb_regs dut_u(.clk(clk), .nrst(nrst), .ce(ce), .req(req), .rdata(rdata), .rvalid(rvalid),
		.ntc_hot_cross(ntc_hot_cross), .cfg(cfg), .boost_hot_stop(boost_hot_stop),
		.thermistor_fault_flag(thermistor_fault_flag));
	ctb_host host_u(.clk(clk), .req(req), .rdata(rdata), .rvalid(rvalid));
	// compare and count
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fails++;
			$display("wrong value at %0t ns: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// read must answer with rvalid and the expected byte
	task automatic read_check(input logic [7:0] a, input logic [7:0] exp);
		host_u.rd(a, d, ok);
		check(16'(ok), 16'h0001);
		check(16'(d), 16'(exp));
	endtask
	// verdict
	task automatic final_report();
		$display("compared %0d, mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// 250 MHz clock
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// watchdog: the tests need well under 1000 cycles
	initial begin
		#20000;
		fails++;
		final_report();
	end
	// test sequence
	initial begin
		nrst = 1'b0;
		ce = 1'b1;
		ntc_hot_cross = 3'h0;
		fails = 0;
		n_compared = 0;
		repeat (4) @(posedge clk);
		nrst <= 1'b1;
		#1;
		check(16'({cfg.term_en, cfg.wd_period_s, cfg.safety_timer_en}), 16'h0251);
		check(16'(cfg.fast_charge_time_limit), 16'h000C);
		check(16'(cfg.otg_target_mv), 16'h1386);
		check(16'({cfg.die_regulation_temp_select, cfg.hot_select}), 16'h01E0);
		read_check(8'h05, 8'h9C);
		read_check(8'h06, 8'h73);
		$display("reset test done");
		// every watchdog and fast-charge code, termination and timer toggled
		for (int i = 0; i < 4; i++) begin
			host_u.wr(8'h05, {i[0], 1'b0, i[1:0], ~i[0], i[1:0], 1'b0});
			check(16'({cfg.term_en, cfg.safety_timer_en, cfg.wd_en}), 16'({i[0], ~i[0], i != 0}));
			check(16'({cfg.wd_period_s, cfg.fast_charge_time_limit}), 16'({wd_tab[i], fct_tab[i]}));
		end
		$display("timer test done");
		// every boost code, with hot select and regulation codes cycling
		for (int i = 0; i < 16; i++) begin
			host_u.wr(8'h06, {i[3:0], i[1:0], i[3:2]});
			check(16'(cfg.otg_target_mv), 16'h11C6 + 16'(64 * i));
			check(16'({cfg.die_regulation_temp_select, cfg.hot_select}), 16'({die_regulation_temp_select_tab[i[3:2]], i[1:0]}));
			check(16'(cfg.boost_hot_protect_en), 16'(i[1:0] != 2'h3));
		end
		$display("boost test done");
		// each select against every comparator pattern; select 11 keeps the fault on the 33 % lane
		for (int s = 0; s < 4; s++) begin
			host_u.wr(8'h06, {4'h7, s[1:0], 2'h3});
			for (int x = 0; x < 8; x++) begin
				@(posedge clk);
				ntc_hot_cross <= x[2:0];
				@(posedge clk);
				#1;
				check(16'({boost_hot_stop, thermistor_fault_flag}), 16'({s != 3 && x[s], s == 3 ? x[0] : x[s]}));
			end
		end
		ntc_hot_cross <= 3'h0;
		$display("thermal test done");
		// reserved bits kept, unmapped address ignored and read as zero
		host_u.wr_rd(8'h05, 8'hC3, d, ok);
		check(16'({ok, d}), 16'h01C3);
		host_u.wr(8'h05, 8'h41);
		read_check(8'h05, 8'h41);
		host_u.wr(8'h07, 8'hFF);
		read_check(8'h07, 8'h00);
		read_check(8'h05, 8'h41);
		read_check(8'h06, 8'h7F);
		$display("reserved test done");
		// a write while ce is low must be ignored; the stored byte survives the freeze
		@(posedge clk);
		ce <= 1'b0;
		host_u.wr(8'h05, 8'h9C);
		@(posedge clk);
		ce <= 1'b1;
		read_check(8'h05, 8'h41);
		$display("enable test done");
		final_report();
	end
endmodule
